// *** inc/perf_report_defines.svh ***
// Offsets, field positions, reset values and timing counts of the report generator
// Assumes an 8-bit register port and a line-rate clock of 20 MHz
`ifndef PERF_REPORT_DEFINES_SVH
`define PERF_REPORT_DEFINES_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_CONFIG 8'h78
`define OFS_IRQ_STATUS 8'h7A
`define OFS_OCTET_TWO 8'h7B
`define OFS_OCTET_THREE 8'h7C
`define OFS_OCTET_FOUR 8'h7D
`define OFS_PAYLOAD_HIGH 8'h7E
`define OFS_PAYLOAD_LOW 8'h7F

// ----------------------------------------
// Config bits
// ----------------------------------------
`define BIT_AUTO_REFRESH 0
`define BIT_IRQ_ENABLE 1
`define BIT_FORCE_CRC 2
`define CONFIG_MASK 8'h3F

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_CONFIG 8'h00
`define RST_OCTET_TWO 8'h38
`define RST_OCTET_THREE 8'h01
`define RST_OCTET_FOUR 8'h03
`define SERVICE_POINT_ID 6'h0E

// ----------------------------------------
// Thresholds and timing
// ----------------------------------------
`define CRC_LIM_ONE 9'd1
`define CRC_LIM_TWO 9'd5
`define CRC_LIM_THREE 9'd10
`define CRC_LIM_FOUR 9'd100
`define CRC_LIM_FIVE 9'd319
`define CRC_LIM_SIX 9'd320
`define CLOCK_HZ 20000000
`define SECOND_NS 1000000000
`define WINDOW_3MS_NS 3000000
`define CLOCK_NS 50
`define WINDOW_3MS_CYCLES (`WINDOW_3MS_NS / `CLOCK_NS)
`define SECOND_CYCLES (`SECOND_NS / `CLOCK_NS)

`endif

// *** inc/perf_report_pkg.sv ***
// Types shared by the report generator
// Assumes nothing beyond the defines header
package perf_report_pkg;
    typedef logic [8:0] crc_count_t;
    typedef logic [7:0] octet_t;
endpackage

// *** hdl/event_window.sv ***
// Severe framing detector: two framing-bit errors within a 3 ms window
// Assumes event pulses are synchronous to i_clock
`timescale 1ns/100ps
`include "perf_report_defines.svh"
module event_window (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_reset,
    // Events
    input wire logic i_event,
    input wire logic i_clear,
    // Result
    output logic o_severe
);
    localparam int unsigned WIN = `WINDOW_3MS_CYCLES;
    logic [16:0] age;
    logic armed;

    // ----------------------------------------
    // Window tracking
    // ----------------------------------------
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            armed <= 1'b0;
            age <= 17'h00000;
        end else if (i_event) begin
            armed <= 1'b1;
            age <= 17'h00000;
        end else if (armed && age < 17'(WIN - 1)) begin
            age <= age + 17'h00001;
        end else begin
            armed <= 1'b0;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_severe <= 1'b0;
        end else if (i_event && armed) begin
            o_severe <= 1'b1;
        end else if (i_clear) begin
            o_severe <= 1'b0;
        end
    end

    a_severe_pair: assert property (@(posedge i_clock) disable iff (i_reset)
        (i_event && armed && !i_clear) |=> o_severe)
        else $error("Second framing error in window did not set severe");
endmodule

// *** hdl/perf_report_gen.sv ***
// One-second line performance report generator with 8-bit register port
// Assumes event inputs are pins from the line side, synchronised here
`timescale 1ns/100ps
`include "perf_report_defines.svh"
module perf_report_gen #(
    parameter int unsigned SECOND_CYCLES = `SECOND_CYCLES
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_reset,
    // Register port
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_write,
    input wire logic i_read,
    output logic [7:0] o_rdata,
    // Line events
    input wire logic i_crc_error,
    input wire logic i_line_violation,
    input wire logic i_slip,
    input wire logic i_framing_error,
    input wire logic i_loopback_active,
    // Interrupt and report
    output logic o_irq_out_n,
    output logic o_second_strobe
);
    // ----------------------------------------
    // Registers and state
    // ----------------------------------------
    logic [7:0] config_reg;
    perf_report_pkg::octet_t octet_two;
    perf_report_pkg::octet_t octet_three;
    perf_report_pkg::octet_t octet_four;
    perf_report_pkg::octet_t payload_high;
    perf_report_pkg::octet_t payload_low;
    logic second_ready_flag;
    logic [24:0] second_count;
    logic second_tick;
    perf_report_pkg::crc_count_t crc_count;
    logic line_violation_seen;
    logic slip_seen;
    logic framing_bit_error_seen;
    logic severe_framing_event;
    logic [1:0] report_seq_counter;
    logic [3:0] sync1;
    logic [3:0] sync2;
    logic [3:0] sync3;
    logic [3:0] ev;
    logic loop_s1;
    logic loop_s2;
    logic report_auto_refresh;
    logic report_irq_enable;
    logic force_continuous_crc_report;
    logic status_read;
    perf_report_pkg::octet_t next_high;
    perf_report_pkg::octet_t next_low;

    assign report_auto_refresh = config_reg[`BIT_AUTO_REFRESH];
    assign report_irq_enable = config_reg[`BIT_IRQ_ENABLE];
    assign force_continuous_crc_report = config_reg[`BIT_FORCE_CRC];
    assign status_read = i_read && (i_addr == `OFS_IRQ_STATUS);

    function automatic logic in_range(input perf_report_pkg::crc_count_t n,
                                      input perf_report_pkg::crc_count_t lo,
                                      input perf_report_pkg::crc_count_t hi);
        in_range = (n > lo) && (n <= hi);
    endfunction

    // ----------------------------------------
    // Input synchronisers and edge detect
    // ----------------------------------------
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            sync1 <= 4'h0;
            sync2 <= 4'h0;
            sync3 <= 4'h0;
            loop_s1 <= 1'b0;
            loop_s2 <= 1'b0;
        end else begin
            sync1 <= {i_framing_error, i_slip, i_line_violation, i_crc_error};
            sync2 <= sync1;
            sync3 <= sync2;
            loop_s1 <= i_loopback_active;
            loop_s2 <= loop_s1;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_edge
            assign ev[g] = sync2[g] && !sync3[g];
        end
    endgenerate

    // ----------------------------------------
    // One-second timer
    // ----------------------------------------
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            second_count <= 25'h0000000;
            second_tick <= 1'b0;
        end else if (second_count == 25'(SECOND_CYCLES - 1)) begin
            second_count <= 25'h0000000;
            second_tick <= 1'b1;
        end else begin
            second_count <= second_count + 25'h0000001;
            second_tick <= 1'b0;
        end
    end

    // ----------------------------------------
    // Per-second event counters
    // ----------------------------------------
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            crc_count <= 9'h000;
            line_violation_seen <= 1'b0;
            slip_seen <= 1'b0;
            framing_bit_error_seen <= 1'b0;
        end else if (second_tick) begin
            crc_count <= 9'(ev[0]);
            line_violation_seen <= ev[1];
            slip_seen <= ev[2];
            framing_bit_error_seen <= ev[3];
        end else begin
            if (ev[0] && crc_count != 9'h1FF) begin
                crc_count <= crc_count + 9'h001;
            end
            if (ev[1]) begin
                line_violation_seen <= 1'b1;
            end
            if (ev[2]) begin
                slip_seen <= 1'b1;
            end
            if (ev[3]) begin
                framing_bit_error_seen <= 1'b1;
            end
        end
    end

    event_window event_window_inst (
        .i_clock(i_clock),
        .i_reset(i_reset),
        .i_event(ev[3]),
        .i_clear(second_tick),
        .o_severe(severe_framing_event)
    );

    // ----------------------------------------
    // Report encoding
    // ----------------------------------------
    always_comb begin
        next_high = 8'h00;
        next_low = 8'h00;
        next_high[7] = in_range(crc_count, `CRC_LIM_TWO, `CRC_LIM_THREE);
        next_high[6] = line_violation_seen;
        next_high[5] = in_range(crc_count, `CRC_LIM_THREE, `CRC_LIM_FOUR);
        next_high[2] = in_range(crc_count, `CRC_LIM_FOUR, `CRC_LIM_FIVE);
        next_high[1] = slip_seen;
        next_high[0] = crc_count >= `CRC_LIM_SIX;
        next_low[7] = framing_bit_error_seen && !severe_framing_event;
        next_low[6] = severe_framing_event;
        next_low[5] = loop_s2;
        next_low[4] = crc_count == `CRC_LIM_ONE;
        next_low[2] = in_range(crc_count, `CRC_LIM_ONE, `CRC_LIM_TWO);
        next_low[1:0] = report_seq_counter;
        if (force_continuous_crc_report) begin
            next_high[7] = 1'b0;
            next_high[5] = 1'b0;
            next_high[2] = 1'b0;
            next_high[0] = 1'b1;
            next_low[7] = 1'b0;
            next_low[6] = 1'b1;
            next_low[4] = 1'b0;
            next_low[2] = 1'b0;
        end
    end

    // ----------------------------------------
    // Payload latch, sequence and ready flag
    // ----------------------------------------
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            payload_high <= 8'h00;
            payload_low <= 8'h00;
            report_seq_counter <= 2'h0;
            o_second_strobe <= 1'b0;
        end else begin
            o_second_strobe <= second_tick && report_auto_refresh;
            if (second_tick && report_auto_refresh) begin
                payload_high <= next_high;
                payload_low <= next_low;
                report_seq_counter <= report_seq_counter + 2'h1;
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            second_ready_flag <= 1'b0;
        end else if (second_tick && report_auto_refresh) begin
            second_ready_flag <= 1'b1;
        end else if (status_read) begin
            second_ready_flag <= 1'b0;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_irq_out_n <= 1'b1;
        end else begin
            o_irq_out_n <= !(report_irq_enable && second_ready_flag);
        end
    end

    // ----------------------------------------
    // Register writes
    // ----------------------------------------
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            config_reg <= `RST_CONFIG;
            octet_two <= `RST_OCTET_TWO;
            octet_three <= `RST_OCTET_THREE;
            octet_four <= `RST_OCTET_FOUR;
        end else if (i_write) begin
            case (i_addr)
                `OFS_CONFIG: config_reg <= i_wdata & `CONFIG_MASK;
                `OFS_OCTET_TWO: octet_two <= {`SERVICE_POINT_ID, i_wdata[1:0]};
                `OFS_OCTET_THREE: octet_three <= i_wdata;
                `OFS_OCTET_FOUR: octet_four <= i_wdata;
                default: ;
            endcase
        end
    end

    // ----------------------------------------
    // Register reads
    // ----------------------------------------
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_rdata <= 8'h00;
        end else if (i_read) begin
            case (i_addr)
                `OFS_CONFIG: o_rdata <= config_reg;
                `OFS_IRQ_STATUS: o_rdata <= {7'h00, second_ready_flag};
                `OFS_OCTET_TWO: o_rdata <= octet_two;
                `OFS_OCTET_THREE: o_rdata <= octet_three;
                `OFS_OCTET_FOUR: o_rdata <= octet_four;
                `OFS_PAYLOAD_HIGH: o_rdata <= payload_high;
                `OFS_PAYLOAD_LOW: o_rdata <= payload_low;
                default: o_rdata <= 8'h00;
            endcase
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_refresh_off: assert property (@(posedge i_clock) disable iff (i_reset)
        !report_auto_refresh |=> $stable(payload_high) && $stable(payload_low))
        else $error("Payload changed with refresh off");
    a_irq_drive: assert property (@(posedge i_clock) disable iff (i_reset)
        (report_irq_enable && second_ready_flag) |=> !o_irq_out_n)
        else $error("Interrupt not driven low");
    a_force_crc: assert property (@(posedge i_clock) disable iff (i_reset)
        (second_tick && report_auto_refresh && force_continuous_crc_report)
        |=> payload_high[0] && payload_low[6] && !payload_low[7] && !payload_low[4])
        else $error("Force CRC pattern wrong");
    a_flag_set: assert property (@(posedge i_clock) disable iff (i_reset)
        (second_tick && report_auto_refresh) |=> second_ready_flag)
        else $error("Ready flag not set at boundary");
    a_read_clear: assert property (@(posedge i_clock) disable iff (i_reset)
        (status_read && !second_tick) |=> !second_ready_flag ##1 o_irq_out_n)
        else $error("Status read did not clear flag");
    a_sap_fixed: assert property (@(posedge i_clock) disable iff (i_reset)
        octet_two[7:2] == `SERVICE_POINT_ID)
        else $error("Service point id changed");
    a_seq_step: assert property (@(posedge i_clock) disable iff (i_reset)
        (second_tick && report_auto_refresh)
        |=> report_seq_counter == $past(report_seq_counter) + 2'h1)
        else $error("Sequence counter did not step");
    a_count_clear: assert property (@(posedge i_clock) disable iff (i_reset)
        second_tick |=> crc_count <= 9'h001)
        else $error("CRC counter not cleared at boundary");
    a_second_period: assert property (@(posedge i_clock) disable iff (i_reset)
        second_tick |=> !second_tick)
        else $error("Second tick too frequent");
    a_tick_align: assert property (@(posedge i_clock) disable iff (i_reset)
        second_tick |-> second_count == 25'h0000000)
        else $error("Second tick off the count boundary");
    a_flag_only_tick: assert property (@(posedge i_clock) disable iff (i_reset)
        (!second_ready_flag && !(second_tick && report_auto_refresh)) |=> !second_ready_flag)
        else $error("Ready flag set away from a boundary");
    a_irq_quiet: assert property (@(posedge i_clock) disable iff (i_reset)
        !report_irq_enable |=> o_irq_out_n)
        else $error("Interrupt driven while disabled");

    // ----------------------------------------
    // Report checks
    // ----------------------------------------
    a_payload_hold: assert property (@(posedge i_clock) disable iff (i_reset)
        !(second_tick && report_auto_refresh) |=> $stable(payload_high) && $stable(payload_low))
        else $error("Payload changed without a ready flag");
    a_line_sticky: assert property (@(posedge i_clock) disable iff (i_reset)
        (line_violation_seen && !second_tick) |=> line_violation_seen)
        else $error("Line violation bit lost within a second");
    a_slip_sticky: assert property (@(posedge i_clock) disable iff (i_reset)
        (slip_seen && !second_tick) |=> slip_seen)
        else $error("Slip bit lost within a second");
    a_severe_excl: assert property (@(posedge i_clock) disable iff (i_reset)
        payload_low[6] |-> !payload_low[7])
        else $error("Framing bit set with severe event");
    a_bucket_single: assert property (
        @(posedge i_clock) disable iff (i_reset)
        $onehot0({payload_high[7], payload_high[5], payload_high[2], payload_high[0],
                  payload_low[4], payload_low[2]}))
        else $error("More than one CRC bucket set");
    a_bucket_one: assert property (@(posedge i_clock) disable iff (i_reset)
        (second_tick && report_auto_refresh && !force_continuous_crc_report
         && crc_count == `CRC_LIM_ONE) |=> payload_low[4])
        else $error("Bucket one not set for a single error");
    a_bucket_six: assert property (@(posedge i_clock) disable iff (i_reset)
        (second_tick && report_auto_refresh && crc_count >= `CRC_LIM_SIX) |=> payload_high[0])
        else $error("Bucket six not set for many errors");
    a_loop_follow: assert property (@(posedge i_clock) disable iff (i_reset)
        (second_tick && report_auto_refresh) |=> payload_low[5] == $past(loop_s2))
        else $error("Loopback bit not latched");
endmodule

// *** bench/perf_report_gen_bench.sv ***
// Self-checking bench for the one-second report generator
// Assumes the defines header on the include path and a shortened second
`timescale 1ns/100ps
`include "perf_report_defines.svh"
module perf_report_gen_bench;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    localparam int unsigned SC = 2000;
    typedef struct packed {
        logic [3:0] mask;
        logic [8:0] cnt;
        logic loop;
        logic [7:0] cfg;
        logic [7:0] hi;
        logic [7:0] lo;
    } row_t;
    logic i_clock = 1'b0;
    logic i_reset = 1'b1;
    logic [7:0] i_addr = 8'h00;
    logic [7:0] i_wdata = 8'h00;
    logic i_write = 1'b0;
    logic i_read = 1'b0;
    logic [7:0] o_rdata;
    logic i_crc_error = 1'b0;
    logic i_line_violation = 1'b0;
    logic i_slip = 1'b0;
    logic i_framing_error = 1'b0;
    logic i_loopback_active = 1'b0;
    logic o_irq_out_n;
    logic o_second_strobe;
    int fail_count = 0;
    int checked = 0;
    int n_strobe = 0;
    logic [1:0] seq_exp = 2'b00;
    // Events {crc, violation, slip, framing}, count, loopback, config, high, low
    row_t rows [0:14] = '{
        '{4'h0, 9'd0, 1'b0, 8'h03, 8'h00, 8'h00},
        '{4'h8, 9'd1, 1'b0, 8'h03, 8'h00, 8'h10},
        '{4'h8, 9'd2, 1'b0, 8'h03, 8'h00, 8'h04},
        '{4'h8, 9'd5, 1'b0, 8'h03, 8'h00, 8'h04},
        '{4'h8, 9'd6, 1'b0, 8'h03, 8'h80, 8'h00},
        '{4'h8, 9'd10, 1'b0, 8'h03, 8'h80, 8'h00},
        '{4'h8, 9'd11, 1'b0, 8'h03, 8'h20, 8'h00},
        '{4'h8, 9'd100, 1'b0, 8'h03, 8'h20, 8'h00},
        '{4'h8, 9'd101, 1'b0, 8'h03, 8'h04, 8'h00},
        '{4'h8, 9'd319, 1'b0, 8'h03, 8'h04, 8'h00},
        '{4'h8, 9'd320, 1'b0, 8'h03, 8'h01, 8'h00},
        '{4'h6, 9'd1, 1'b1, 8'h01, 8'h42, 8'h20},
        '{4'h1, 9'd1, 1'b0, 8'h03, 8'h00, 8'h80},
        '{4'h1, 9'd2, 1'b0, 8'h03, 8'h00, 8'h40},
        '{4'h8, 9'd2, 1'b0, 8'h07, 8'h01, 8'h40}
    };

    perf_report_gen #(
        .SECOND_CYCLES(SC)
    ) perf_report_gen_inst (
        .i_clock(i_clock),
        .i_reset(i_reset),
        .i_addr(i_addr),
        .i_wdata(i_wdata),
        .i_write(i_write),
        .i_read(i_read),
        .o_rdata(o_rdata),
        .i_crc_error(i_crc_error),
        .i_line_violation(i_line_violation),
        .i_slip(i_slip),
        .i_framing_error(i_framing_error),
        .i_loopback_active(i_loopback_active),
        .o_irq_out_n(o_irq_out_n),
        .o_second_strobe(o_second_strobe)
    );

    initial begin
        forever #25 i_clock = ~i_clock;
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask

    task automatic check(input string n, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", n, e, g);
            fail_count++;
        end
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        i_addr = a;
        i_wdata = d;
        i_write = 1'b1;
        tick(1);
        i_write = 1'b0;
        tick(1);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input string n);
        i_addr = a;
        i_read = 1'b1;
        tick(1);
        i_read = 1'b0;
        tick(1);
        check(n, e, o_rdata);
    endtask

    task automatic fire(input logic [3:0] m, input int n);
        repeat (n) begin
            {i_crc_error, i_line_violation, i_slip, i_framing_error} = m;
            tick(1);
            {i_crc_error, i_line_violation, i_slip, i_framing_error} = 4'h0;
            tick(3);
        end
    endtask

    task automatic wait_strobe();
        int k;
        k = 0;
        while (o_second_strobe !== 1'b1 && k < 2 * SC + 100) begin
            tick(1);
            k++;
        end
        if (o_second_strobe !== 1'b1) begin
            $display("ERROR second strobe expected 1 seen %b", o_second_strobe);
            fail_count++;
            report_and_stop();
        end
    endtask

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        tick(8);
        i_reset = 1'b0;
        rd_chk(`OFS_CONFIG, 8'h00, "config");
        rd_chk(`OFS_IRQ_STATUS, 8'h00, "status");
        rd_chk(`OFS_OCTET_TWO, 8'h38, "octet two");
        rd_chk(`OFS_OCTET_THREE, 8'h01, "octet three");
        rd_chk(`OFS_OCTET_FOUR, 8'h03, "octet four");
        rd_chk(`OFS_PAYLOAD_HIGH, 8'h00, "payload high");
        rd_chk(`OFS_PAYLOAD_LOW, 8'h00, "payload low");
        check("irq idle", 8'h01, {7'h00, o_irq_out_n});
        reg_write(`OFS_CONFIG, 8'hC7);
        rd_chk(`OFS_CONFIG, 8'h07, "config");
        reg_write(`OFS_OCTET_TWO, 8'hFF);
        rd_chk(`OFS_OCTET_TWO, 8'h3B, "octet two");
        reg_write(`OFS_OCTET_THREE, 8'hA5);
        rd_chk(`OFS_OCTET_THREE, 8'hA5, "octet three");
        reg_write(`OFS_OCTET_FOUR, 8'h5A);
        rd_chk(`OFS_OCTET_FOUR, 8'h5A, "octet four");
        reg_write(`OFS_PAYLOAD_HIGH, 8'h55);
        rd_chk(`OFS_PAYLOAD_HIGH, 8'h00, "payload high");
        reg_write(8'h79, 8'h55);
        rd_chk(8'h79, 8'h00, "unmapped");
        $display("test registers done");
        reg_write(`OFS_CONFIG, 8'h03);
        wait_strobe();
        rd_chk(`OFS_PAYLOAD_LOW, 8'h00, "first payload low");
        seq_exp = 2'b01;
        for (int i = 0; i < 15; i++) begin
            reg_write(`OFS_CONFIG, rows[i].cfg);
            i_loopback_active = rows[i].loop;
            fire(rows[i].mask, int'(rows[i].cnt));
            wait_strobe();
            tick(1);
            check("irq", {7'h00, ~rows[i].cfg[1]}, {7'h00, o_irq_out_n});
            rd_chk(`OFS_IRQ_STATUS, 8'h01, "status");
            tick(1);
            check("irq released", 8'h01, {7'h00, o_irq_out_n});
            rd_chk(`OFS_PAYLOAD_HIGH, rows[i].hi, "payload high");
            rd_chk(`OFS_PAYLOAD_LOW, rows[i].lo | {6'h00, seq_exp}, "payload low");
            seq_exp = seq_exp + 2'b01;
            i_loopback_active = 1'b0;
            $display("test second %0d done", i);
        end
        reg_write(`OFS_CONFIG, 8'h02);
        fire(4'h8, 3);
        repeat (2 * SC + 100) begin
            tick(1);
            if (o_second_strobe === 1'b1) begin
                n_strobe++;
            end
        end
        check("strobe count", 8'h00, n_strobe[7:0]);
        check("irq refresh off", 8'h01, {7'h00, o_irq_out_n});
        rd_chk(`OFS_IRQ_STATUS, 8'h00, "status");
        rd_chk(`OFS_PAYLOAD_HIGH, 8'h01, "held payload high");
        rd_chk(`OFS_PAYLOAD_LOW, 8'h40 | {6'h00, seq_exp - 2'b01}, "held low");
        $display("test refresh off done");
        i_reset = 1'b1;
        tick(8);
        i_reset = 1'b0;
        check("irq after reset", 8'h01, {7'h00, o_irq_out_n});
        rd_chk(`OFS_CONFIG, 8'h00, "config after reset");
        rd_chk(`OFS_OCTET_FOUR, 8'h03, "octet four after reset");
        rd_chk(`OFS_PAYLOAD_LOW, 8'h00, "payload low after reset");
        $display("test reset done");
        report_and_stop();
    end
endmodule
